/* src/cos_regs.svh */
// Constants of the combined overcurrent status block.
// Assumes it is included by the package and by the modules cos_hold and cos_top.
`ifndef COS_REGS_SVH
`define COS_REGS_SVH

// ********************************************************************
// Widths and limits
// ********************************************************************
`define COS_DLY_W 16
`define COS_CUR_W 16
`define COS_PH_N 3
`define COS_STAGES_MAX 32

// ********************************************************************
// Reset values
// ********************************************************************
`define COS_EN_RST 1'b1
`define COS_REP_RST 1'b0
`define COS_DLY_RST 16'h0000
`define COS_CUR_RST 16'h0000

`endif

/* src/cos_pkg.sv */
// Types shared by the combined overcurrent status block.
// Assumes cos_regs.svh is on the include path.
`default_nettype none
`include "cos_regs.svh"

package cos_pkg;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [`COS_PH_N-1:0] start;
		logic [`COS_PH_N-1:0] trip;
		logic [`COS_CUR_W-1:0] current;
	} cos_stage_type;

	typedef struct packed {
		logic phase_start_on_event_enable;
		logic phase_start_off_event_enable;
		logic combined_start_on_event_enable;
		logic combined_start_off_event_enable;
		logic phase_trip_on_event_enable;
		logic phase_trip_off_event_enable;
		logic combined_trip_on_event_enable;
		logic combined_trip_off_event_enable;
		logic repeated_fault_event_setting;
		logic [`COS_DLY_W-1:0] start_status_clear_delay;
		logic [`COS_DLY_W-1:0] trip_status_clear_delay;
	} cos_cfg_type;

	typedef struct packed {
		logic [`COS_PH_N-1:0] ph_start_on;
		logic [`COS_PH_N-1:0] ph_start_off;
		logic comb_start_on;
		logic comb_start_off;
		logic [`COS_PH_N-1:0] ph_trip_on;
		logic [`COS_PH_N-1:0] ph_trip_off;
		logic comb_trip_on;
		logic comb_trip_off;
	} cos_evt_type;

endpackage
`default_nettype wire

/* src/cos_hold.sv */
// One status flag with its clear delay counted in seconds.
// Assumes tick is a one-cycle pulse once a second on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "cos_regs.svh"

module cos_hold #(
	parameter int DW = `COS_DLY_W
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic raw,
	input wire logic tick,
	input wire logic [DW-1:0] delay,
	output logic flag_q
);

	logic [DW-1:0] cnt_q;
	logic last;

	if (DW < 1 || DW > 32)
	begin
		$error("cos_hold: DW out of range");
	end

	// The first tick after the fall may come at once, so the hold lies
	// between delay-1 and delay whole seconds.
	assign last = (delay == '0) || (tick && (cnt_q == delay - DW'(1)));

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			cnt_q <= '0;
		else if (raw || !flag_q)
			cnt_q <= '0;
		else if (tick)
			cnt_q <= cnt_q + DW'(1);
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			flag_q <= 1'b0;
		else if (raw)
			flag_q <= 1'b1;
		else if (flag_q && last)
			flag_q <= 1'b0;
	end

	property p_raw_sets;
		@(posedge core_clk) disable iff (!rstn)
		raw |=> flag_q;
	endproperty
	a_raw_sets: assert property (p_raw_sets)
		else $error("Flag not set by a present condition.");

	property p_no_early_clear;
		@(posedge core_clk) disable iff (!rstn)
		flag_q && !raw && !tick && delay != '0 |=> flag_q;
	endproperty
	a_no_early_clear: assert property (p_no_early_clear)
		else $error("Flag cleared without a second tick.");

	property p_zero_clear;
		@(posedge core_clk) disable iff (!rstn)
		flag_q && !raw && delay == '0 |=> !flag_q;
	endproperty
	a_zero_clear: assert property (p_zero_clear)
		else $error("Flag held although the delay is zero.");

	property p_restart;
		@(posedge core_clk) disable iff (!rstn)
		raw ##1 !raw |-> cnt_q == '0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("Clear delay not restarted.");

endmodule
`default_nettype wire

/* src/cos_event.sv */
// On and off events of a group of flags, one-cycle pulses.
// Assumes flag comes from a flip-flop on core_clk.
`timescale 1ns/100ps
`default_nettype none

module cos_event #(
	parameter int W = 3
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [W-1:0] flag,
	input wire logic on_en,
	input wire logic off_en,
	input wire logic [W-1:0] on_ok,
	input wire logic [W-1:0] off_ok,
	output logic [W-1:0] on_q,
	output logic [W-1:0] off_q
);

	logic [W-1:0] prev_q;

	if (W < 1)
	begin
		$error("cos_event: W out of range");
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			prev_q <= '0;
		else
			prev_q <= flag;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			on_q <= '0;
			off_q <= '0;
		end
		else
		begin
			on_q <= flag & ~prev_q & {W{on_en}} & on_ok;
			off_q <= ~flag & prev_q & {W{off_en}} & off_ok;
		end
	end

	property p_steady;
		@(posedge core_clk) disable iff (!rstn)
		flag == prev_q |=> on_q == '0 && off_q == '0;
	endproperty
	a_steady: assert property (p_steady)
		else $error("Event raised on a steady flag.");

	property p_on_en;
		@(posedge core_clk) disable iff (!rstn)
		!on_en |=> on_q == '0;
	endproperty
	a_on_en: assert property (p_on_en)
		else $error("On-event raised while disabled.");

	property p_off_en;
		@(posedge core_clk) disable iff (!rstn)
		!off_en |=> off_q == '0;
	endproperty
	a_off_en: assert property (p_off_en)
		else $error("Off-event raised while disabled.");

endmodule
`default_nettype wire

/* src/cos_top.sv */
// Combined overcurrent status: phase and combined start and trip flags,
// their events, and the latest fault current.
// Assumes stage inputs and sec_tick are driven by logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "cos_regs.svh"

module cos_top #(
	parameter int NS = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sec_tick,
	input wire logic [NS-1:0] stage_enable,
	input wire cos_pkg::cos_stage_type [NS-1:0] stages,
	input wire logic cfg_wr,
	input wire logic cfg_auth,
	input wire cos_pkg::cos_cfg_type cfg_wdata,
	input wire logic cur_wr,
	input wire logic [`COS_CUR_W-1:0] cur_wdata,
	output logic phase1_start_flag,
	output logic phase2_start_flag,
	output logic phase3_start_flag,
	output logic combined_start_flag,
	output logic phase1_trip_flag,
	output logic phase2_trip_flag,
	output logic phase3_trip_flag,
	output logic combined_trip_flag,
	output logic [`COS_CUR_W-1:0] latest_fault_current,
	output var cos_pkg::cos_evt_type events,
	output var cos_pkg::cos_cfg_type cfg_readback,
	output logic cfg_rejected
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [`COS_PH_N-1:0] cos_gather(
		input cos_pkg::cos_stage_type [NS-1:0] st,
		input logic [NS-1:0] en,
		input logic trip
	);
		logic [`COS_PH_N-1:0] acc;
		acc = '0;
		for (int i = 0; i < NS; i++)
		begin
			if (en[i])
				acc = acc | (trip ? st[i].trip : st[i].start);
		end
		return acc;
	endfunction

	// A phase keeps the right to an off-event only if it reported the
	// rise; otherwise suppressed faults would log unpaired off-events.
	function automatic logic [`COS_PH_N-1:0] cos_next_rep(
		input logic [`COS_PH_N-1:0] flag,
		input logic [`COS_PH_N-1:0] rep,
		input logic [`COS_PH_N-1:0] ok
	);
		return flag & (rep | ok);
	endfunction

	// Lowest stage index wins when several stages trip together.
	function automatic logic [`COS_CUR_W-1:0] cos_first(
		input logic [NS-1:0] rise,
		input cos_pkg::cos_stage_type [NS-1:0] st
	);
		logic [`COS_CUR_W-1:0] v;
		v = '0;
		for (int i = NS - 1; i >= 0; i--)
		begin
			if (rise[i])
				v = st[i].current;
		end
		return v;
	endfunction

	if (NS < 1 || NS > `COS_STAGES_MAX)
	begin
		$error("cos_top: NS out of range");
	end

	cos_pkg::cos_cfg_type cfg_q;
	logic rej_q;
	logic [`COS_PH_N-1:0] raw_start;
	logic [`COS_PH_N-1:0] raw_trip;
	logic [`COS_PH_N-1:0] start_flag;
	logic [`COS_PH_N-1:0] trip_flag;
	logic any_start;
	logic any_trip;
	logic comb_start_q;
	logic comb_trip_q;
	logic [`COS_PH_N-1:0] start_rep_q;
	logic [`COS_PH_N-1:0] trip_rep_q;
	logic [`COS_PH_N-1:0] start_on_ok;
	logic [`COS_PH_N-1:0] start_off_ok;
	logic [`COS_PH_N-1:0] trip_on_ok;
	logic [`COS_PH_N-1:0] trip_off_ok;
	logic [NS-1:0] act;
	logic [NS-1:0] act_q;
	logic [NS-1:0] trip_rise;
	logic [`COS_CUR_W-1:0] capture;
	logic [`COS_CUR_W-1:0] cur_q;

	// ****************************************************************
	// Settings
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cfg_q.phase_start_on_event_enable <= `COS_EN_RST;
			cfg_q.phase_start_off_event_enable <= `COS_EN_RST;
			cfg_q.combined_start_on_event_enable <= `COS_EN_RST;
			cfg_q.combined_start_off_event_enable <= `COS_EN_RST;
			cfg_q.phase_trip_on_event_enable <= `COS_EN_RST;
			cfg_q.phase_trip_off_event_enable <= `COS_EN_RST;
			cfg_q.combined_trip_on_event_enable <= `COS_EN_RST;
			cfg_q.combined_trip_off_event_enable <= `COS_EN_RST;
			cfg_q.repeated_fault_event_setting <= `COS_REP_RST;
			cfg_q.start_status_clear_delay <= `COS_DLY_RST;
			cfg_q.trip_status_clear_delay <= `COS_DLY_RST;
		end
		else if (cfg_wr && cfg_auth)
			cfg_q <= cfg_wdata;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rej_q <= 1'b0;
		else
			rej_q <= cfg_wr && !cfg_auth;
	end

	// ****************************************************************
	// Flags
	// ****************************************************************
	assign raw_start = cos_gather(stages, stage_enable, 1'b0);
	assign raw_trip = cos_gather(stages, stage_enable, 1'b1);

	for (genvar p = 0; p < `COS_PH_N; p++)
	begin : g_ph
		cos_hold #(.DW(`COS_DLY_W)) u_start (
			.core_clk(core_clk), .rstn(rstn), .raw(raw_start[p]),
			.tick(sec_tick), .flag_q(start_flag[p]),
			.delay(cfg_q.start_status_clear_delay));
		cos_hold #(.DW(`COS_DLY_W)) u_trip (
			.core_clk(core_clk), .rstn(rstn), .raw(raw_trip[p]),
			.tick(sec_tick), .flag_q(trip_flag[p]),
			.delay(cfg_q.trip_status_clear_delay));
	end

	assign any_start = |start_flag;
	assign any_trip = |trip_flag;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			comb_start_q <= 1'b0;
			comb_trip_q <= 1'b0;
		end
		else
		begin
			comb_start_q <= any_start;
			comb_trip_q <= any_trip;
		end
	end

	// ****************************************************************
	// Events
	// ****************************************************************
	// With repeats off, only phases that rise while the combined flag is
	// still clear report; later phases of the same fault stay silent.
	assign start_on_ok = cfg_q.repeated_fault_event_setting ?
		'1 : {`COS_PH_N{!comb_start_q}};
	assign trip_on_ok = cfg_q.repeated_fault_event_setting ?
		'1 : {`COS_PH_N{!comb_trip_q}};
	assign start_off_ok = cfg_q.repeated_fault_event_setting ?
		'1 : start_rep_q;
	assign trip_off_ok = cfg_q.repeated_fault_event_setting ?
		'1 : trip_rep_q;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			start_rep_q <= '0;
			trip_rep_q <= '0;
		end
		else
		begin
			start_rep_q <= cos_next_rep(start_flag, start_rep_q, start_on_ok);
			trip_rep_q <= cos_next_rep(trip_flag, trip_rep_q, trip_on_ok);
		end
	end

	cos_event #(.W(`COS_PH_N)) u_ev_ph_start (
		.core_clk(core_clk), .rstn(rstn), .flag(start_flag),
		.on_en(cfg_q.phase_start_on_event_enable),
		.off_en(cfg_q.phase_start_off_event_enable),
		.on_ok(start_on_ok), .off_ok(start_off_ok),
		.on_q(events.ph_start_on), .off_q(events.ph_start_off));

	cos_event #(.W(1)) u_ev_comb_start (
		.core_clk(core_clk), .rstn(rstn), .flag(comb_start_q),
		.on_en(cfg_q.combined_start_on_event_enable),
		.off_en(cfg_q.combined_start_off_event_enable),
		.on_ok(1'b1), .off_ok(1'b1),
		.on_q(events.comb_start_on), .off_q(events.comb_start_off));

	cos_event #(.W(`COS_PH_N)) u_ev_ph_trip (
		.core_clk(core_clk), .rstn(rstn), .flag(trip_flag),
		.on_en(cfg_q.phase_trip_on_event_enable),
		.off_en(cfg_q.phase_trip_off_event_enable),
		.on_ok(trip_on_ok), .off_ok(trip_off_ok),
		.on_q(events.ph_trip_on), .off_q(events.ph_trip_off));

	cos_event #(.W(1)) u_ev_comb_trip (
		.core_clk(core_clk), .rstn(rstn), .flag(comb_trip_q),
		.on_en(cfg_q.combined_trip_on_event_enable),
		.off_en(cfg_q.combined_trip_off_event_enable),
		.on_ok(1'b1), .off_ok(1'b1),
		.on_q(events.comb_trip_on), .off_q(events.comb_trip_off));

	// ****************************************************************
	// Latest fault current
	// ****************************************************************
	for (genvar s = 0; s < NS; s++)
	begin : g_act
		assign act[s] = stage_enable[s] && (|stages[s].trip);
	end

	assign trip_rise = act & ~act_q;
	assign capture = cos_first(trip_rise, stages);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			act_q <= '0;
		else
			act_q <= act;
	end

	// A fresh fault outranks a simultaneous software write.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			cur_q <= `COS_CUR_RST;
		else if (|trip_rise)
			cur_q <= capture;
		else if (cur_wr)
			cur_q <= cur_wdata;
	end

	assign phase1_start_flag = start_flag[0];
	assign phase2_start_flag = start_flag[1];
	assign phase3_start_flag = start_flag[2];
	assign phase1_trip_flag = trip_flag[0];
	assign phase2_trip_flag = trip_flag[1];
	assign phase3_trip_flag = trip_flag[2];
	assign combined_start_flag = comb_start_q;
	assign combined_trip_flag = comb_trip_q;
	assign latest_fault_current = cur_q;
	assign cfg_readback = cfg_q;
	assign cfg_rejected = rej_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_comb_start;
		@(posedge core_clk) disable iff (!rstn)
		any_start != comb_start_q |=> comb_start_q == $past(any_start);
	endproperty
	a_comb_start: assert property (p_comb_start)
		else $error("Combined start flag not the OR of phases.");

	property p_comb_trip;
		@(posedge core_clk) disable iff (!rstn)
		any_trip ##1 !any_trip |-> comb_trip_q;
	endproperty
	a_comb_trip: assert property (p_comb_trip)
		else $error("Combined trip flag dropped early.");

	property p_disabled;
		@(posedge core_clk) disable iff (!rstn)
		stage_enable == '0 && !any_start && !any_trip |=>
			!any_start && !any_trip;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("Disabled stage raised a flag.");

	property p_cfg_reject;
		@(posedge core_clk) disable iff (!rstn)
		cfg_wr && !cfg_auth |=> rej_q && cfg_q == $past(cfg_q);
	endproperty
	a_cfg_reject: assert property (p_cfg_reject)
		else $error("Unauthorised setting write accepted.");

	property p_cfg_take;
		@(posedge core_clk) disable iff (!rstn)
		cfg_wr && cfg_auth |=> !rej_q && cfg_q == $past(cfg_wdata);
	endproperty
	a_cfg_take: assert property (p_cfg_take)
		else $error("Authorised setting write lost.");

	property p_suppress;
		@(posedge core_clk) disable iff (!rstn)
		!cfg_q.repeated_fault_event_setting |=>
			(events.ph_trip_on == '0 || !$past(comb_trip_q)) &&
			(events.ph_start_on == '0 || !$past(comb_start_q));
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("Repeated trip event of a growing fault.");

	property p_capture;
		@(posedge core_clk) disable iff (!rstn)
		|trip_rise |=> cur_q == $past(capture);
	endproperty
	a_capture: assert property (p_capture)
		else $error("Fault current not captured.");

	property p_cur_wr;
		@(posedge core_clk) disable iff (!rstn)
		cur_wr && trip_rise == '0 |=> cur_q == $past(cur_wdata);
	endproperty
	a_cur_wr: assert property (p_cur_wr)
		else $error("Fault current write lost.");

endmodule
`default_nettype wire

/* verification/cos_stage_model.sv */
// Model of the overcurrent stages that feed the combined status block.
// Assumes the bench updates one stage at a time on core_clk.
`timescale 1ns/100ps
`default_nettype none

module cos_stage_model #(
	parameter int NS = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic set_wr,
	input wire logic [4:0] set_idx,
	input wire cos_pkg::cos_stage_type set_val,
	output var cos_pkg::cos_stage_type [NS-1:0] stages
);
	// Stage outputs are levels that persist until the stage changes them.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			stages <= '0;
		else if (set_wr)
			stages[set_idx] <= set_val;
	end
endmodule
`default_nettype wire

/* verification/cos_top_tb_top.sv */
// Self-checking bench of the combined overcurrent status block.
// Assumes cos_pkg and cos_stage_model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module cos_top_tb_top;
	localparam int NS = 8;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic sec_tick = 1'b0;
	logic [NS-1:0] stage_enable = 8'hFF;
	logic cfg_wr = 1'b0;
	logic cfg_auth = 1'b0;
	cos_pkg::cos_cfg_type cfg_wdata = '0;
	logic cur_wr = 1'b0;
	logic [15:0] cur_wdata = 16'h0000;
	logic set_wr = 1'b0;
	logic [4:0] set_idx = 5'h00;
	cos_pkg::cos_stage_type set_val = '0;
	cos_pkg::cos_stage_type [NS-1:0] stages;
	logic p1s, p2s, p3s, cs, p1t, p2t, p3t, ct, cfg_rejected;
	logic [15:0] latest_fault_current;
	cos_pkg::cos_evt_type events, acc, e;
	cos_pkg::cos_cfg_type cfg_readback, cfg;
	int bad_count = 0;
	int compares = 0;

	cos_stage_model #(.NS(NS)) cos_stage_model_inst (.core_clk(core_clk),
		.rstn(rstn), .set_wr(set_wr), .set_idx(set_idx),
		.set_val(set_val), .stages(stages));

	cos_top #(.NS(NS)) cos_top_inst (.core_clk(core_clk), .rstn(rstn),
		.sec_tick(sec_tick), .stage_enable(stage_enable), .stages(stages),
		.cfg_wr(cfg_wr), .cfg_auth(cfg_auth), .cfg_wdata(cfg_wdata),
		.cur_wr(cur_wr), .cur_wdata(cur_wdata), .phase1_start_flag(p1s),
		.phase2_start_flag(p2s), .phase3_start_flag(p3s),
		.combined_start_flag(cs), .phase1_trip_flag(p1t),
		.phase2_trip_flag(p2t), .phase3_trip_flag(p3t),
		.combined_trip_flag(ct), .latest_fault_current(latest_fault_current),
		.events(events), .cfg_readback(cfg_readback),
		.cfg_rejected(cfg_rejected));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp,
		input string what);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t %s got %0h expected %0h", $time, what, got,
				exp);
		end
	endtask

	// Values read here are those from before the edge, so a one-cycle
	// event pulse is never missed by the accumulator.
	task automatic step(input int n = 1);
		repeat (n)
		begin
			@(posedge core_clk);
			acc = acc | events;
		end
	endtask

	task automatic stg(input int idx, input logic [2:0] st,
		input logic [2:0] tr, input logic [15:0] cur);
		step();
		set_wr <= 1'b1;
		set_idx <= idx[4:0];
		set_val <= '{start: st, trip: tr, current: cur};
		step();
		set_wr <= 1'b0;
	endtask

	task automatic tick();
		step();
		sec_tick <= 1'b1;
		step();
		sec_tick <= 1'b0;
	endtask

	task automatic cfgw(input logic auth, input cos_pkg::cos_cfg_type v);
		step();
		cfg_wr <= 1'b1;
		cfg_auth <= auth;
		cfg_wdata <= v;
		step();
		cfg_wr <= 1'b0;
		step();
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_settings();
		cfg = '1;
		cfg.repeated_fault_event_setting = 1'b0;
		cfg.start_status_clear_delay = 16'h0000;
		cfg.trip_status_clear_delay = 16'h0000;
		cmp(cfg_readback, cfg, "reset settings");
		cmp({p1s, p2s, p3s, cs, p1t, p2t, p3t, ct}, 8'h00, "reset flags");
		cfgw(1'b0, '0);
		cmp(cfg_rejected, 1'b1, "reject pulse");
		cmp(cfg_readback, cfg, "refused write");
		cfg.start_status_clear_delay = 16'h0002;
		cfgw(1'b1, cfg);
		cmp(cfg_rejected, 1'b0, "no reject");
		cmp(cfg_readback, cfg, "accepted write");
		$display("test settings done");
	endtask

	task automatic t_start();
		acc = '0;
		stg(0, 3'b001, 3'b000, 16'h0000);
		step(4);
		cmp(p1s, 1'b1, "phase1 start");
		cmp(cs, 1'b1, "combined start");
		e = '0;
		e.ph_start_on = 3'b001;
		e.comb_start_on = 1'b1;
		cmp(acc, e, "start on events");
		acc = '0;
		step(6);
		cmp(acc, 16'h0000, "steady flag");
		stg(0, 3'b000, 3'b000, 16'h0000);
		tick();
		stg(0, 3'b001, 3'b000, 16'h0000);
		stg(0, 3'b000, 3'b000, 16'h0000);
		tick();
		step(3);
		cmp(p1s, 1'b1, "restarted delay");
		cmp(acc, 16'h0000, "held flag");
		tick();
		step(4);
		cmp({p1s, cs}, 2'b00, "start cleared");
		e = '0;
		e.ph_start_off = 3'b001;
		e.comb_start_off = 1'b1;
		cmp(acc, e, "start off events");
		$display("test start done");
	endtask

	task automatic t_disabled();
		step();
		stage_enable <= 8'h00;
		stg(0, 3'b111, 3'b111, 16'h1234);
		step(4);
		cmp({p1s, p2s, p3s, p1t, p2t, p3t}, 6'h00, "disabled flags");
		cmp(latest_fault_current, 16'h0000, "disabled current");
		stg(0, 3'b000, 3'b000, 16'h0000);
		step();
		stage_enable <= 8'hFF;
		$display("test disabled done");
	endtask

	task automatic t_trip();
		cfg.phase_trip_on_event_enable = 1'b0;
		cfg.phase_trip_off_event_enable = 1'b0;
		cfgw(1'b1, cfg);
		acc = '0;
		stg(2, 3'b000, 3'b010, 16'h0ABC);
		step(4);
		cmp({p2t, ct, p1t, p3t}, 4'hC, "trip flags");
		cmp(latest_fault_current, 16'h0ABC, "fault capture");
		stg(2, 3'b000, 3'b000, 16'h0ABC);
		step(4);
		cmp({p2t, ct}, 2'b00, "zero delay clear");
		e = '0;
		e.comb_trip_on = 1'b1;
		e.comb_trip_off = 1'b1;
		cmp(acc, e, "trip events gated");
		step();
		cur_wr <= 1'b1;
		cur_wdata <= 16'h5A5A;
		step();
		cur_wr <= 1'b0;
		step(2);
		cmp(latest_fault_current, 16'h5A5A, "current write");
		$display("test trip done");
	endtask

	task automatic t_repeat(input logic rep, input logic [2:0] on_exp,
		input logic [2:0] off_exp);
		cfg.repeated_fault_event_setting = rep;
		cfg.phase_trip_on_event_enable = 1'b1;
		cfg.phase_trip_off_event_enable = 1'b1;
		cfgw(1'b1, cfg);
		acc = '0;
		stg(0, 3'b001, 3'b001, 16'h0000);
		step(4);
		stg(0, 3'b011, 3'b011, 16'h0000);
		step(4);
		cmp(acc.ph_start_on, on_exp, "growing fault on");
		cmp(acc.ph_trip_on, on_exp, "growing trip on");
		acc = '0;
		stg(0, 3'b000, 3'b000, 16'h0000);
		tick();
		tick();
		step(4);
		cmp(acc.ph_start_off, off_exp, "growing fault off");
		cmp(acc.ph_trip_off, off_exp, "growing trip off");
		$display("test repeat done");
	endtask

	initial
	begin
		forever #2 core_clk = ~core_clk;
	end

	initial
	begin
		#200000;
		bad_count++;
		$display("[ERR] %0t run did not finish", $time);
		report_and_stop();
	end

	initial
	begin
		acc = '0;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		t_settings();
		t_start();
		t_disabled();
		t_trip();
		t_repeat(1'b0, 3'b001, 3'b001);
		t_repeat(1'b1, 3'b011, 3'b011);
		report_and_stop();
	end
endmodule
`default_nettype wire
